// ===== burst_seq_pkg.sv
// Shared constants and types for the burst-mode output sequencer.
// Assumes a single 100 MHz sample clock domain and a 32-bit AHB-Lite register bus.
package burst_seq_pkg;

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] COUNT_OFFSET  = 8'h08;

  // Control register field positions.
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_AUTO_BIT  = 1;
  localparam int CTRL_DECIM_BIT = 2;
  localparam int CTRL_EXP_LSB   = 8;
  localparam int CTRL_EXP_MSB   = 12;

  // Burst exponent limits and fixed exponents.
  localparam logic [4:0] EXP_RESET = 5'h0a;
  localparam logic [4:0] EXP_MIN   = 5'h0a;
  localparam logic [4:0] EXP_MAX   = 5'h19;
  localparam logic [4:0] INIT_EXP  = 5'h0d;
  localparam logic [4:0] LOCK_ADD  = 5'h03;

  // Sample counter width: holds 2^(EXP_MAX+3) without overflow.
  localparam int CNT_W = 29;

  // Synchronisation figures: counter width in bits, counts in sample clock cycles.
  localparam int         SYNC_W          = 5;
  localparam logic [4:0] SYNC_LAST       = 5'h1f;
  localparam logic [5:0] INVALID_SAMPLES = 6'h24;

  // Low-resolution formats.
  localparam int LOW7_BITS  = 7;
  localparam int LOW11_BITS = 11;

  typedef enum logic [4:0] {
    ST_OFF   = 5'b00001,
    ST_LOCK  = 5'b00010,
    ST_ARMED = 5'b00100,
    ST_DELAY = 5'b01000,
    ST_BURST = 5'b10000
  } burst_state_t;

  typedef struct packed {
    logic [4:0] burstExp;
    logic       lowResDecim;
    logic       autoTrigger;
    logic       burstEnable;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '{
    burstExp:    EXP_RESET,
    lowResDecim: 1'b0,
    autoTrigger: 1'b0,
    burstEnable: 1'b0
  };

  typedef struct packed {
    logic [11:0] chanA;
    logic [11:0] chanB;
  } sample_pair_t;

endpackage : burst_seq_pkg

// ===== burst_output_sequencer_sync.sv
// Burst-mode output sequencer with multi-device sync marker and DDR clock output.
// Assumes samples arrive on the sample clock; trigger and sync come from pins and
// are synchronised here. Registers are reached over a zero-wait AHB-Lite slave.
//
// Local design decisions: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps

// Functional notes
// RULE_01: Auto mode starts with 8192 low-res samples.
// RULE_02: Auto mode bursts right after last low-res.
// RULE_03: Auto ignores trigger; ready pulses one cycle.
// RULE_04: High-res flag spans burst; exponent latched late.
// RULE_05: Burst is 2^N full samples, N 10..25.
// RULE_06: After burst: low-res, flag low, lockout.
// RULE_07: Trigger edges ignored until lockout completes.
// RULE_08: Setting selects 7-bit or 11-bit low-res.
// RULE_09: Seven-bit option keeps full rate timing.
// RULE_10: Eleven-bit option holds each sample four slots.
// RULE_11: Decimated path keeps latency, drops three of four.
// RULE_12: Sync resets logic, starts 32-cycle marker counter.
// RULE_13: Far end sends single or 32-periodic sync.
// RULE_14: Sync sampled on sample clock rising edges.
// RULE_15: Output invalid for 36 samples after sync.
// RULE_16: Marker starts at next output clock rise.
// RULE_17: Sync at new phase restarts the counter.
// RULE_18: Falling-phase sync stretches output clock half cycle.
// RULE_19: Marker driven on both channel buses.
// RULE_20: Far end discards 18 samples when decimating.
// RULE_21: Manual mode: ready after lockout, edge starts burst.
// RULE_22: Burst starts one to two output clocks later.
// RULE_23: Exponent resets to 10, applies next low-res period.
// RULE_24: Enable gives 8192 low-res samples, triggers refused.
// RULE_25: Low-res unused low bits are driven zero.
// RULE_26: Counters sized for the largest lockout period.
module burst_output_sequencer_sync (
  input  wire logic                        clock,             // Sample clock, 100 MHz.
  input  wire logic                        rstn,              // Synchronous reset, active low.
  input  wire logic                        hsel,              // AHB slave select.
  input  wire logic [7:0]                  haddr,             // AHB byte address.
  input  wire logic [1:0]                  htrans,            // AHB transfer type.
  input  wire logic                        hwrite,            // AHB write strobe.
  input  wire logic [2:0]                  hsize,             // AHB transfer size.
  input  wire logic [31:0]                 hwdata,            // AHB write data.
  input  wire logic                        hready,            // AHB bus ready.
  output logic      [31:0]                 hrdata,            // AHB read data.
  output logic                             hreadyout,         // AHB slave ready.
  output logic                             hresp,             // AHB response, always OKAY.
  input  wire burst_seq_pkg::sample_pair_t sampleIn,          // Converted samples.
  input  wire logic                        burstTriggerIn,    // Trigger pin level.
  input  wire logic                        syncPulseInput,    // Sync pin level.
  output logic      [11:0]                 chanADataOut,      // Channel A data bus.
  output logic      [11:0]                 chanBDataOut,      // Channel B data bus.
  output logic                             triggerReadyFlag,  // Trigger may be given.
  output logic                             highResFlag,       // Full-resolution data.
  output logic                             syncMarkerOut,     // Marker on bus A.
  output logic                             syncMarkerOutB,    // Marker on bus B.
  output logic                             outputDataValid,   // Low while data invalid.
  output logic                             chanAOutClock,     // Channel A DDR clock.
  output logic                             outputDdrClock     // Channel B DDR clock.
);

  function automatic logic [burst_seq_pkg::CNT_W-1:0] pow2(input logic [4:0] e);
    logic [burst_seq_pkg::CNT_W-1:0] one;
    one  = {{(burst_seq_pkg::CNT_W-1){1'b0}}, 1'b1};
    pow2 = one << e;
  endfunction : pow2

  function automatic logic [4:0] clampExp(input logic [4:0] e);
    if (e < burst_seq_pkg::EXP_MIN) begin
      clampExp = burst_seq_pkg::EXP_MIN;
    end else if (e > burst_seq_pkg::EXP_MAX) begin
      clampExp = burst_seq_pkg::EXP_MAX;
    end else begin
      clampExp = e;
    end
  endfunction : clampExp

  // Keeps the top bits and zeroes the rest.
  function automatic logic [11:0] keepTop(input logic [11:0] s, input logic decim);
    logic [11:0] m7;
    logic [11:0] m11;
    m7  = 12'hfff << (12 - burst_seq_pkg::LOW7_BITS);
    m11 = 12'hfff << (12 - burst_seq_pkg::LOW11_BITS);
    keepTop = decim ? (s & m11) : (s & m7);  // [RULE_25]
  endfunction : keepTop

  burst_seq_pkg::ctrl_t           ctrl_reg;
  burst_seq_pkg::burst_state_t    state_reg;
  logic [burst_seq_pkg::CNT_W-1:0] cnt_reg;
  logic [4:0]                      expActive_reg;
  logic                            firstLock_reg;
  logic                            autoPrev_reg;
  logic                            autoRise;
  logic                            trigMeta_reg;
  logic                            trigSync_reg;
  logic                            trigPrev_reg;
  logic                            syncMeta_reg;
  logic                            syncSync_reg;
  logic                            syncPrev_reg;
  logic                            syncSeen_reg;
  logic [burst_seq_pkg::SYNC_W-1:0] syncCnt_reg;
  logic [5:0]                      invalidCnt_reg;
  logic                            ddrClk_reg;
  logic [1:0]                      decimPhase_reg;
  burst_seq_pkg::sample_pair_t     held_reg;
  logic                            addrValid_reg;
  logic                            addrWrite_reg;
  logic [7:0]                      addrLatch_reg;
  logic                            trigRise;
  logic                            syncRise;
  logic                            syncReset;
  logic                            addrTaken;
  logic [burst_seq_pkg::CNT_W-1:0] lockLen;
  logic [burst_seq_pkg::CNT_W-1:0] burstLen;
  logic [31:0]                     readMux;

  // Pin inputs pass two flip-flops before any logic reads them.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      trigMeta_reg <= 1'b0;
      trigSync_reg <= 1'b0;
      trigPrev_reg <= 1'b0;
      syncMeta_reg <= 1'b0;
      syncSync_reg <= 1'b0;
      syncPrev_reg <= 1'b0;
    end else begin
      trigMeta_reg <= burstTriggerIn;
      trigSync_reg <= trigMeta_reg;
      trigPrev_reg <= trigSync_reg;
      syncMeta_reg <= syncPulseInput;  // [RULE_14]
      syncSync_reg <= syncMeta_reg;
      syncPrev_reg <= syncSync_reg;
    end
  end

  assign trigRise = trigSync_reg & ~trigPrev_reg;
  assign syncRise = syncSync_reg & ~syncPrev_reg;  // [RULE_14]
  // A periodic sync that lands on the running phase leaves everything alone.
  assign syncReset = syncRise & (~syncSeen_reg | (syncCnt_reg != burst_seq_pkg::SYNC_LAST));  // [RULE_17]

  assign lockLen  = firstLock_reg ? pow2(burst_seq_pkg::INIT_EXP)
                                  : pow2(expActive_reg + burst_seq_pkg::LOCK_ADD);  // [RULE_06]
  assign burstLen = pow2(expActive_reg);  // [RULE_05]

  // Sync counter, marker and DDR output clock.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      syncSeen_reg   <= 1'b0;
      syncCnt_reg    <= '0;
      syncMarkerOut  <= 1'b0;
      syncMarkerOutB <= 1'b0;
      ddrClk_reg     <= 1'b0;
      chanAOutClock  <= 1'b0;
      outputDdrClock <= 1'b0;
    end else begin
      if (syncReset) begin
        syncSeen_reg <= 1'b1;
        syncCnt_reg  <= '0;  // [RULE_12] [RULE_17]
        // Forcing high stretches a high clock by half a cycle, or rises a low one.
        ddrClk_reg     <= 1'b1;  // [RULE_18]
        chanAOutClock  <= 1'b1;
        outputDdrClock <= 1'b1;
        syncMarkerOut  <= 1'b1;  // [RULE_16] [RULE_19]
        syncMarkerOutB <= 1'b1;
      end else begin
        syncCnt_reg    <= syncCnt_reg + 5'h01;  // [RULE_12]
        ddrClk_reg     <= ~ddrClk_reg;
        chanAOutClock  <= ~ddrClk_reg;
        outputDdrClock <= ~ddrClk_reg;
        // Marker covers one output clock period at each counter wrap.
        syncMarkerOut  <= syncSeen_reg & ((syncCnt_reg == burst_seq_pkg::SYNC_LAST)
                          | (syncCnt_reg == 5'h00));  // [RULE_19]
        syncMarkerOutB <= syncSeen_reg & ((syncCnt_reg == burst_seq_pkg::SYNC_LAST)
                          | (syncCnt_reg == 5'h00));  // [RULE_19]
      end
    end
  end

  // Invalid-data window after a sync restart.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      invalidCnt_reg  <= '0;
      outputDataValid <= 1'b1;
    end else if (syncReset) begin
      invalidCnt_reg  <= burst_seq_pkg::INVALID_SAMPLES - 6'h01;  // [RULE_15]
      outputDataValid <= 1'b0;
    end else if (invalidCnt_reg != 6'h00) begin
      invalidCnt_reg  <= invalidCnt_reg - 6'h01;
      outputDataValid <= 1'b0;
    end else begin
      outputDataValid <= 1'b1;
    end
  end

  // Switching auto mode on restarts the initial lockout, even while enabled.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      autoPrev_reg <= 1'b0;
    end else begin
      autoPrev_reg <= ctrl_reg.autoTrigger;
    end
  end

  assign autoRise = ctrl_reg.autoTrigger & ~autoPrev_reg;  // [RULE_01]

  // Burst sequencing state machine.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_reg     <= burst_seq_pkg::ST_OFF;
      cnt_reg       <= '0;
      expActive_reg <= burst_seq_pkg::EXP_RESET;
      firstLock_reg <= 1'b1;
    end else if (!ctrl_reg.burstEnable) begin
      state_reg     <= burst_seq_pkg::ST_OFF;
      cnt_reg       <= '0;
      firstLock_reg <= 1'b1;
    end else if (syncReset || autoRise) begin
      // A sync restart, or auto mode switched on, sends the sequencer back to its enable point.
      state_reg     <= burst_seq_pkg::ST_LOCK;  // [RULE_12] [RULE_01]
      cnt_reg       <= '0;
      firstLock_reg <= 1'b1;
      expActive_reg <= ctrl_reg.burstExp;
    end else begin
      case (state_reg)
        burst_seq_pkg::ST_OFF: begin
          state_reg     <= burst_seq_pkg::ST_LOCK;  // [RULE_01] [RULE_24]
          cnt_reg       <= '0;
          firstLock_reg <= 1'b1;
          expActive_reg <= ctrl_reg.burstExp;
        end
        burst_seq_pkg::ST_LOCK: begin
          if (cnt_reg == lockLen - 1'b1) begin
            cnt_reg <= '0;
            if (ctrl_reg.autoTrigger) begin
              state_reg <= burst_seq_pkg::ST_BURST;  // [RULE_02]
            end else begin
              state_reg <= burst_seq_pkg::ST_ARMED;  // [RULE_07] [RULE_21]
            end
          end else begin
            cnt_reg <= cnt_reg + 1'b1;  // [RULE_26]
          end
        end
        burst_seq_pkg::ST_ARMED: begin
          if (ctrl_reg.autoTrigger) begin
            state_reg <= burst_seq_pkg::ST_BURST;
          end else if (trigRise) begin
            state_reg <= burst_seq_pkg::ST_DELAY;  // [RULE_21]
          end
        end
        burst_seq_pkg::ST_DELAY: begin
          state_reg <= burst_seq_pkg::ST_BURST;  // [RULE_22]
          cnt_reg   <= '0;
        end
        burst_seq_pkg::ST_BURST: begin
          if (cnt_reg == burstLen - 1'b1) begin
            cnt_reg       <= '0;
            state_reg     <= burst_seq_pkg::ST_LOCK;  // [RULE_06]
            firstLock_reg <= 1'b0;
            expActive_reg <= ctrl_reg.burstExp;  // [RULE_04] [RULE_23]
          end else begin
            cnt_reg <= cnt_reg + 1'b1;  // [RULE_05]
          end
        end
        default: begin
          state_reg <= burst_seq_pkg::ST_OFF;
          cnt_reg   <= '0;
        end
      endcase
    end
  end

  // Decimation phase and held sample for the 11-bit option.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      decimPhase_reg <= '0;
      held_reg       <= '0;
    end else begin
      decimPhase_reg <= decimPhase_reg + 2'h1;  // [RULE_10]
      if (decimPhase_reg == 2'h0) begin
        held_reg <= sampleIn;  // [RULE_11]
      end
    end
  end

  // Output data and flags share one register stage so latency never changes.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      chanADataOut     <= '0;
      chanBDataOut     <= '0;
      highResFlag      <= 1'b0;
      triggerReadyFlag <= 1'b0;
    end else begin
      if (state_reg == burst_seq_pkg::ST_BURST || state_reg == burst_seq_pkg::ST_OFF) begin
        chanADataOut <= sampleIn.chanA;  // [RULE_05]
        chanBDataOut <= sampleIn.chanB;
      end else if (!ctrl_reg.lowResDecim) begin
        chanADataOut <= keepTop(sampleIn.chanA, 1'b0);  // [RULE_08] [RULE_09]
        chanBDataOut <= keepTop(sampleIn.chanB, 1'b0);
      end else if (decimPhase_reg == 2'h0) begin
        chanADataOut <= keepTop(sampleIn.chanA, 1'b1);  // [RULE_10] [RULE_11]
        chanBDataOut <= keepTop(sampleIn.chanB, 1'b1);
      end else begin
        chanADataOut <= keepTop(held_reg.chanA, 1'b1);  // [RULE_10]
        chanBDataOut <= keepTop(held_reg.chanB, 1'b1);
      end
      highResFlag <= (state_reg == burst_seq_pkg::ST_BURST);  // [RULE_04] [RULE_22]
      if (ctrl_reg.autoTrigger) begin
        triggerReadyFlag <= (state_reg == burst_seq_pkg::ST_BURST)
                            && (cnt_reg == '0);  // [RULE_03]
      end else begin
        triggerReadyFlag <= (state_reg == burst_seq_pkg::ST_ARMED);  // [RULE_21]
      end
    end
  end

  // AHB-Lite slave: zero wait states, word registers, reads zero off the map.
  assign addrTaken = hsel & htrans[1] & hready;

  always_comb begin
    readMux = 32'h0000_0000;
    case (haddr)
      burst_seq_pkg::CTRL_OFFSET: begin
        readMux[burst_seq_pkg::CTRL_EN_BIT]    = ctrl_reg.burstEnable;
        readMux[burst_seq_pkg::CTRL_AUTO_BIT]  = ctrl_reg.autoTrigger;
        readMux[burst_seq_pkg::CTRL_DECIM_BIT] = ctrl_reg.lowResDecim;
        readMux[burst_seq_pkg::CTRL_EXP_MSB:burst_seq_pkg::CTRL_EXP_LSB] = ctrl_reg.burstExp;
      end
      burst_seq_pkg::STATUS_OFFSET: begin
        readMux[4:0]   = state_reg;
        readMux[8]     = highResFlag;
        readMux[9]     = triggerReadyFlag;
        readMux[10]    = syncSeen_reg;
        readMux[11]    = outputDataValid;
        readMux[12]    = firstLock_reg;
        readMux[20:16] = expActive_reg;
        readMux[28:24] = syncCnt_reg;
      end
      burst_seq_pkg::COUNT_OFFSET: begin
        readMux[burst_seq_pkg::CNT_W-1:0] = cnt_reg;
      end
      default: begin
        readMux = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      addrValid_reg <= 1'b0;
      addrWrite_reg <= 1'b0;
      addrLatch_reg <= '0;
      hrdata        <= '0;
      hreadyout     <= 1'b0;
      hresp         <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready) begin
        addrValid_reg <= addrTaken;
        addrWrite_reg <= hwrite;
        addrLatch_reg <= haddr;
      end
      if (addrTaken && !hwrite) begin
        hrdata <= readMux;
      end
    end
  end

  // Register writes land in the data phase.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctrl_reg <= burst_seq_pkg::CTRL_RESET;  // [RULE_23]
    end else if (addrValid_reg && addrWrite_reg
                 && addrLatch_reg == burst_seq_pkg::CTRL_OFFSET) begin
      ctrl_reg.burstEnable <= hwdata[burst_seq_pkg::CTRL_EN_BIT];
      ctrl_reg.autoTrigger <= hwdata[burst_seq_pkg::CTRL_AUTO_BIT];
      ctrl_reg.lowResDecim <= hwdata[burst_seq_pkg::CTRL_DECIM_BIT];  // [RULE_08]
      ctrl_reg.burstExp    <= clampExp(
        hwdata[burst_seq_pkg::CTRL_EXP_MSB:burst_seq_pkg::CTRL_EXP_LSB]);  // [RULE_05]
    end
  end

endmodule : burst_output_sequencer_sync

// ===== burst_seq_chk.sv
// Concurrent checks on the sequencer's flags, sync marker and output clocks.
// Assumes it is bound to the sequencer top and sees only that module's ports.
`timescale 1ns/1ps
module burst_seq_chk (
  input wire logic clock,            // Sample clock.
  input wire logic rstn,             // Synchronous reset, active low.
  input wire logic triggerReadyFlag, // Trigger may be given.
  input wire logic highResFlag,      // Full-resolution data.
  input wire logic syncMarkerOut,    // Marker on bus A.
  input wire logic syncMarkerOutB,   // Marker on bus B.
  input wire logic outputDataValid,  // Low while data invalid.
  input wire logic chanAOutClock,    // Channel A DDR clock.
  input wire logic outputDdrClock    // Channel B DDR clock.
);
  logic [31:0] hiRun;
  logic [31:0] loRun;
  logic [7:0]  invRun;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // Run lengths are kept wide so that the longest lockout cannot wrap.
  always_ff @(posedge clock) begin
    if (!rstn || !highResFlag) hiRun <= '0;
    else hiRun <= hiRun + 32'h1;
  end
  always_ff @(posedge clock) begin
    if (!rstn || highResFlag) loRun <= '0;
    else loRun <= loRun + 32'h1;
  end
  always_ff @(posedge clock) begin
    if (!rstn || outputDataValid) invRun <= '0;
    else invRun <= invRun + 8'h1;
  end
  ready_pulse_a: assert property (triggerReadyFlag && highResFlag |-> $rose(highResFlag) ##1 !triggerReadyFlag)
    else $error("ready flag is not a single pulse at burst start");
  burst_len_a: assert property ($fell(highResFlag) |-> hiRun >= 32'd1024 && (hiRun & (hiRun - 32'd1)) == 32'd0)
    else $error("burst length is not a power of two of at least 1024");
  lockout_min_a: assert property ($rose(highResFlag) |-> loRun >= 32'd8192)
    else $error("burst started before the lockout ran out");
  ready_in_burst_a: assert property (highResFlag && $past(highResFlag) |-> !triggerReadyFlag)
    else $error("ready flag high inside a burst");
  start_delay_a: assert property ($fell(triggerReadyFlag) |-> ##[0:4] highResFlag)
    else $error("burst did not follow the accepted trigger");
  invalid_len_a: assert property ($rose(outputDataValid) |-> invRun == 8'd36)
    else $error("invalid window is not 36 samples");
  marker_pair_a: assert property ($rose(syncMarkerOut) |-> ##1 syncMarkerOut ##1 !syncMarkerOut)
    else $error("marker is not two cycles wide");
  marker_period_a: assert property ($rose(syncMarkerOut) && outputDataValid |-> ##32 ($rose(syncMarkerOut) || !outputDataValid))
    else $error("marker period is not 32 cycles");
  marker_both_a: assert property (syncMarkerOut == syncMarkerOutB)
    else $error("marker differs between buses");
  clocks_same_a: assert property (chanAOutClock == outputDdrClock)
    else $error("output clocks differ");
  clock_toggle_a: assert property ($past(rstn) && !$fell(outputDataValid) |-> chanAOutClock != $past(chanAOutClock))
    else $error("output clock stalled outside a sync restart");
endmodule : burst_seq_chk

bind burst_output_sequencer_sync burst_seq_chk u_burst_seq_chk (
  .clock(clock), .rstn(rstn), .triggerReadyFlag(triggerReadyFlag), .highResFlag(highResFlag),
  .syncMarkerOut(syncMarkerOut), .syncMarkerOutB(syncMarkerOutB),
  .outputDataValid(outputDataValid), .chanAOutClock(chanAOutClock),
  .outputDdrClock(outputDdrClock));

// ===== far_end_rx.sv
// Receiving logic model: counts sync markers and output clock rises kept after sync.
// Assumes its inputs come from the sequencer in the sample clock domain.
`timescale 1ns/1ps
module far_end_rx (
  input  wire logic        clock,   // Sample clock.
  input  wire logic        rstn,    // Synchronous reset, active low.
  input  wire logic        ddrClk,  // Output clock from the sequencer.
  input  wire logic        marker,  // Sync marker.
  input  wire logic        valid,   // Data valid flag.
  output logic      [7:0]  markers, // Marker rises seen.
  output logic      [15:0] kept     // Output clock rises since data became valid.
);
  logic ddrPrev;
  logic markPrev;
  always_ff @(posedge clock) begin
    ddrPrev <= ddrClk;
    markPrev <= marker;
    if (!rstn) markers <= '0;
    else if (marker && !markPrev) markers <= markers + 8'h1;
  end
  // With no 2x decimation here, the whole invalid window is dropped, not 18.
  always_ff @(posedge clock) begin
    if (!rstn || !valid) kept <= '0;
    else if (ddrClk && !ddrPrev) kept <= kept + 16'h1;
  end
endmodule : far_end_rx

// ===== tb_top.sv
// Testbench for the burst sequencer: registers over AHB-Lite, burst modes, sync.
// Assumes a 100 MHz clock; the trigger pin is driven from a slow unrelated clock.
`timescale 1ns/1ps
module tb_top;
  logic                        clock, rstn, linkClk, hsel, hwrite, hreadyout, hresp;
  logic [7:0]                  haddr;
  logic [1:0]                  htrans;
  logic [2:0]                  hsize;
  logic [31:0]                 hwdata, hrdata, rd;
  burst_seq_pkg::sample_pair_t sampleIn;
  logic [11:0]                 smp, chanADataOut, chanBDataOut, orv;
  logic                        burstTriggerIn, syncPulseInput, triggerReadyFlag, highResFlag;
  logic                        syncMarkerOut, syncMarkerOutB, outputDataValid;
  logic                        chanAOutClock, outputDdrClock;
  logic [7:0]                  markers;
  logic [15:0]                 kept;
  int                          numErrors, comparisons, cyc, t0, ch;

  burst_output_sequencer_sync u_burst_output_sequencer_sync (.clock(clock), .rstn(rstn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sampleIn(sampleIn), .burstTriggerIn(burstTriggerIn),
    .syncPulseInput(syncPulseInput), .chanADataOut(chanADataOut), .chanBDataOut(chanBDataOut),
    .triggerReadyFlag(triggerReadyFlag), .highResFlag(highResFlag),
    .syncMarkerOut(syncMarkerOut), .syncMarkerOutB(syncMarkerOutB),
    .outputDataValid(outputDataValid), .chanAOutClock(chanAOutClock),
    .outputDdrClock(outputDdrClock));
  far_end_rx u_far_end_rx (.clock(clock), .rstn(rstn), .ddrClk(chanAOutClock),
    .marker(syncMarkerOut), .valid(outputDataValid), .markers(markers), .kept(kept));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    linkClk = 1'b0;
    #3;
    forever #80 linkClk = ~linkClk;
  end
  // A ramp makes every output slot differ, so held samples show up as repeats.
  always @(posedge clock) begin
    smp <= smp + 12'h1;
    sampleIn <= '{chanA: smp, chanB: ~smp};
    cyc <= cyc + 1;
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, numErrors);
    if (numErrors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      numErrors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    n = 0;
    do begin @(posedge clock); n++; end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hwdata <= wd;
    do begin @(posedge clock); n++; end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 100) begin numErrors++; close_out(); end
  endtask : bus
  // Selects 0 burst flag, 1 ready flag, 2 data valid, 3 marker.
  function automatic logic pick(input int w);
    case (w)
      0: return highResFlag;
      1: return triggerReadyFlag;
      2: return outputDataValid;
      default: return syncMarkerOut;
    endcase
  endfunction : pick
  task automatic wait_lvl(input int w, input logic lvl, input int lim);
    int n;
    n = 0;
    while (pick(w) !== lvl && n < lim) begin @(posedge clock); n++; end
    if (n >= lim) begin numErrors++; close_out(); end
  endtask : wait_lvl
  task automatic trig_set(input logic v);
    @(posedge linkClk);
    burstTriggerIn <= v;
    @(posedge clock);
  endtask : trig_set
  task automatic sample();
    logic [11:0] prev;
    ch = 0;
    orv = '0;
    prev = chanADataOut;
    repeat (64) begin
      @(posedge clock);
      if (chanADataOut !== prev) ch++;
      orv = orv | chanADataOut | chanBDataOut;
      prev = chanADataOut;
    end
  endtask : sample

  initial begin
    {rstn, hsel, hwrite, burstTriggerIn, syncPulseInput, cyc, numErrors, comparisons} = '0;
    {haddr, htrans, hwdata, smp} = '0;
    hsize = 3'b010;
    sampleIn = '0;
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    bus(0, 8'h00, 0); chk(rd, 32'h0a00);
    bus(1, 8'h0c, 32'hffff); bus(0, 8'h0c, 0); chk(rd, 0);
    bus(1, 8'h00, 32'h1f00); bus(0, 8'h00, 0); chk(rd, 32'h1900);
    bus(1, 8'h00, 32'h0300); bus(0, 8'h00, 0); chk(rd, 32'h0a00);
    $display("test regs done");
    bus(1, 8'h00, 32'h0a01); t0 = cyc;
    repeat (4) @(posedge clock);
    sample(); chk(ch, 2); chk(orv[4:0], 0);
    trig_set(1); trig_set(0);
    wait_lvl(1, 1, 9000); chk(cyc - t0 >= 8192 && cyc - t0 <= 8200, 1);
    chk(highResFlag, 0);
    trig_set(1); t0 = cyc;
    wait_lvl(0, 1, 20); chk(cyc - t0 <= 12, 1);
    t0 = cyc;
    sample(); chk(ch, 64);
    wait_lvl(0, 0, 2000); chk(cyc - t0, 1024);
    trig_set(0); trig_set(1);
    repeat (50) @(posedge clock);
    chk(highResFlag, 0); chk(triggerReadyFlag, 0);
    trig_set(0);
    $display("test manual done");
    bus(1, 8'h00, 32'h0a07); t0 = cyc;
    repeat (4) @(posedge clock);
    sample(); chk(ch, 16); chk(orv[0], 0);
    trig_set(1); trig_set(0);
    wait_lvl(0, 1, 9000); chk(cyc - t0 >= 8192 && cyc - t0 <= 8200, 1);
    chk(triggerReadyFlag, 1); t0 = cyc;
    @(posedge clock); chk(triggerReadyFlag, 0);
    wait_lvl(0, 0, 2000); chk(cyc - t0, 1024); t0 = cyc;
    wait_lvl(0, 1, 9000); chk(cyc - t0, 8192); t0 = cyc;
    bus(1, 8'h00, 32'h0b07);
    wait_lvl(0, 0, 2000); chk(cyc - t0, 1024); t0 = cyc;
    wait_lvl(0, 1, 17000); chk(cyc - t0, 16384); t0 = cyc;
    wait_lvl(0, 0, 3000); chk(cyc - t0, 2048);
    bus(1, 8'h00, 0);
    $display("test auto done");
    syncPulseInput <= 1'b1;
    wait_lvl(2, 0, 10); t0 = cyc;
    syncPulseInput <= 1'b0;
    wait_lvl(2, 1, 50); chk(cyc - t0, 36);
    wait_lvl(3, 0, 40); wait_lvl(3, 1, 40); t0 = cyc;
    wait_lvl(3, 0, 5); chk(cyc - t0, 2);
    wait_lvl(3, 1, 40); chk(cyc - t0, 32); chk(chanAOutClock, 1);
    chk(syncMarkerOutB, syncMarkerOut); chk(markers >= 2, 1);
    chk(kept >= 25 && kept <= 34, 1);
    repeat (7) @(posedge clock);
    syncPulseInput <= 1'b1;
    wait_lvl(2, 0, 10); chk(syncMarkerOut, 1);
    syncPulseInput <= 1'b0;
    $display("test sync done");
    close_out();
  end
endmodule : tb_top
